// *** src/sec_ctrl.v ***
// serial eeprom controller: reset-time station address load, host
// commands and the three-wire link to a 128 x 8 eeprom.
// assumes a single 10 MHz clock; host ports are in the same domain,
// the eeprom data-out pin is asynchronous and is synchronised here.
`timescale 1ns/10ps
`include "sec_defines.vh"

module sec_ctrl #(
	parameter SCLK_HALF = `SEC_SCLK_HALF,
	parameter TIMEOUT_CYC = `SEC_TIMEOUT_CYC,
	parameter TO_W = `SEC_TO_W
) (
	// clock and reset
	input wire sys_clk,
	input wire nrst,
	input wire soft_rst,
	// command register fields
	input wire [2:0] command_code_field,
	input wire [6:0] eeprom_location_field,
	input wire busy_set,
	input wire timeout_clr,
	output wire command_busy_flag,
	output wire response_timeout_flag,
	output wire address_loaded_flag,
	// data register
	input wire data_wr,
	input wire [7:0] data_in,
	output wire [7:0] eeprom_data_reg,
	// station address registers
	input wire sta_low_wr,
	input wire [31:0] sta_low_in,
	input wire sta_high_wr,
	input wire [15:0] sta_high_in,
	output wire [31:0] station_addr_low_reg,
	output wire [15:0] station_addr_high_reg,
	// pin configuration
	input wire if_disable,
	input wire mon_sel,
	input wire gpo_data,
	input wire gpo_clk,
	input wire mon_data,
	input wire mon_clk,
	// eeprom pins
	output wire chip_select,
	output wire serial_clock_pin,
	input wire serial_data_pin_in,
	output wire serial_data_pin_out,
	output wire serial_data_pin_oe_n
);

	localparam ST_IDLE = 3'h0;
	localparam ST_PREP = 3'h1;
	localparam ST_FRAME = 3'h2;
	localparam ST_GAP = 3'h3;
	localparam ST_POLL = 3'h4;

	localparam [31:0] HALF_LAST_W = SCLK_HALF - 1;
	localparam [31:0] TO_LAST_W = TIMEOUT_CYC - 1;
	localparam [7:0] HALF_LAST = HALF_LAST_W[7:0];
	localparam [TO_W-1:0] TO_LAST = TO_LAST_W[TO_W-1:0];

	reg [2:0] state_r;
	reg [2:0] cmd_r;
	reg [6:0] loc_r;
	reg busy_r;
	reg to_r;
	reg loaded_r;
	reg [7:0] data_r;
	reg [47:0] sta_r;
	reg ld_req_r;
	reg ld_act_r;
	reg [2:0] ld_idx_r;
	reg [7:0] div_r;
	reg sclk_r;
	reg cs_r;
	reg drv_r;
	reg [17:0] sh_r;
	reg [4:0] bit_r;
	reg [7:0] rd_r;
	reg saw_busy_r;
	reg [TO_W-1:0] to_cnt_r;
	reg di_s1_r;
	reg di_s2_r;
	reg pin_cs_r;
	reg pin_clk_r;
	reg pin_do_r;
	reg pin_oe_n_r;
	reg [17:0] frame_nxt;

	wire tick;
	wire is_read;
	wire long_frame;
	wire need_poll;
	wire [4:0] frame_bits;
	wire [5:0] sta_base;
	wire [2:0] idx_inc;

	// outputs straight from registers
	assign command_busy_flag = busy_r;
	assign response_timeout_flag = to_r;
	assign address_loaded_flag = loaded_r;
	assign eeprom_data_reg = data_r;
	assign station_addr_low_reg = sta_r[31:0];
	assign station_addr_high_reg = sta_r[47:32];
	assign chip_select = pin_cs_r;
	assign serial_clock_pin = pin_clk_r;
	assign serial_data_pin_out = pin_do_r;
	assign serial_data_pin_oe_n = pin_oe_n_r;

	// serial clock enable: one pulse every half period while a frame runs
	assign tick = (div_r == HALF_LAST);

	// command classes
	assign is_read = (cmd_r == `SEC_CMD_READ);
	assign long_frame = is_read || (cmd_r == `SEC_CMD_WRITE) || (cmd_r == `SEC_CMD_WRALL);
	assign frame_bits = long_frame ? `SEC_BITS_LONG : `SEC_BITS_SHORT;
	assign need_poll = (cmd_r == `SEC_CMD_WRITE) || (cmd_r == `SEC_CMD_WRALL) ||
		(cmd_r == `SEC_CMD_ERASE) || (cmd_r == `SEC_CMD_ERALL);

	// byte lane of the station address for the current load step
	assign sta_base = {ld_idx_r - 3'h1, 3'h0};
	assign idx_inc = ld_idx_r + 3'h1;

	// frame word: start bit, opcode, location, data, msb first
	always @* begin
		case (cmd_r)
			`SEC_CMD_READ: begin
				frame_nxt = {1'b1, `SEC_OP_READ, loc_r, 8'h00};
			end
			`SEC_CMD_WRITE: begin
				frame_nxt = {1'b1, `SEC_OP_WRITE, loc_r, data_r};
			end
			`SEC_CMD_ERASE: begin
				frame_nxt = {1'b1, `SEC_OP_ERASE, loc_r, 8'h00};
			end
			`SEC_CMD_ERALL: begin
				frame_nxt = {1'b1, `SEC_OP_EXT, `SEC_EXT_ERALL, 5'h00, 8'h00};
			end
			`SEC_CMD_WRALL: begin
				frame_nxt = {1'b1, `SEC_OP_EXT, `SEC_EXT_WRALL, 5'h00, data_r};
			end
			`SEC_CMD_LOCK: begin
				frame_nxt = {1'b1, `SEC_OP_EXT, `SEC_EXT_LOCK, 5'h00, 8'h00};
			end
			`SEC_CMD_UNLOCK: begin
				frame_nxt = {1'b1, `SEC_OP_EXT, `SEC_EXT_UNLOCK, 5'h00, 8'h00};
			end
			default: begin
				frame_nxt = 18'h00000;
			end
		endcase
	end

	// data-out pin synchroniser; only the second stage is read
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			di_s1_r <= 1'b0;
			di_s2_r <= 1'b0;
		end else begin
			di_s1_r <= serial_data_pin_in;
			di_s2_r <= di_s1_r;
		end
	end

	// half-period divider, restarted at each frame so the first edge is clean
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			div_r <= 8'h00;
		end else if (state_r == ST_FRAME || state_r == ST_GAP) begin
			div_r <= tick ? 8'h00 : div_r + 8'h01;
		end else begin
			div_r <= 8'h00;
		end
	end

	// main sequencer: command start, frame shifting, polling, auto-load
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_r <= ST_IDLE;
			cmd_r <= `SEC_CMD_READ;
			loc_r <= `SEC_SIG_LOC;
			busy_r <= 1'b0;
			to_r <= 1'b0;
			loaded_r <= 1'b0;
			data_r <= `SEC_DATA_RST;
			sta_r <= `SEC_STA_RST;
			ld_req_r <= 1'b1;
			ld_act_r <= 1'b0;
			ld_idx_r <= 3'h0;
			sclk_r <= 1'b0;
			cs_r <= 1'b0;
			drv_r <= 1'b0;
			sh_r <= 18'h00000;
			bit_r <= 5'h00;
			rd_r <= 8'h00;
			saw_busy_r <= 1'b0;
			to_cnt_r <= {TO_W{1'b0}};
		end else begin
			// host side writes; hardware updates further down take priority
			if (timeout_clr) begin
				to_r <= 1'b0;
			end
			if (data_wr && !busy_r) begin
				data_r <= data_in;
			end
			// host programs the address itself when no eeprom is found
			if (sta_low_wr && !ld_act_r) begin
				sta_r[31:0] <= sta_low_in;
			end
			if (sta_high_wr && !ld_act_r) begin
				sta_r[47:32] <= sta_high_in;
			end
			// a soft reset queues a fresh load, taken once idle
			if (soft_rst) begin
				ld_req_r <= 1'b1;
			end

			case (state_r)
				ST_IDLE: begin
					sclk_r <= 1'b0;
					cs_r <= 1'b0;
					drv_r <= 1'b0;
					if (ld_req_r) begin
						// reset-time load starts with the signature byte
						ld_req_r <= 1'b0;
						ld_act_r <= 1'b1;
						ld_idx_r <= 3'h0;
						loc_r <= `SEC_SIG_LOC;
						cmd_r <= `SEC_CMD_READ;
						busy_r <= 1'b1;
						loaded_r <= 1'b0;
						state_r <= ST_PREP;
					end else if (busy_set && !if_disable) begin
						// command runs only once the host sets busy
						busy_r <= 1'b1;
						to_r <= 1'b0;
						if (command_code_field == `SEC_CMD_RELOAD) begin
							ld_act_r <= 1'b1;
							ld_idx_r <= 3'h0;
							loc_r <= `SEC_SIG_LOC;
							cmd_r <= `SEC_CMD_READ;
							loaded_r <= 1'b0;
						end else begin
							cmd_r <= command_code_field;
							loc_r <= eeprom_location_field;
						end
						state_r <= ST_PREP;
					end
				end

				ST_PREP: begin
					// select rises with the start bit already on the data pin
					sh_r <= frame_nxt;
					bit_r <= 5'h00;
					sclk_r <= 1'b0;
					cs_r <= 1'b1;
					drv_r <= 1'b1;
					state_r <= ST_FRAME;
				end

				ST_FRAME: begin
					if (tick && !sclk_r) begin
						// rising edge: the eeprom samples the bit now on the pin
						sclk_r <= 1'b1;
						bit_r <= bit_r + 5'h01;
					end else if (tick) begin
						// falling edge: present the next bit, collect read data
						sclk_r <= 1'b0;
						sh_r <= {sh_r[16:0], 1'b0};
						// release half a clock after the last location bit, so the
						// release never moves on the edge where the eeprom samples
						if (is_read && bit_r == `SEC_BITS_ADDR) begin
							drv_r <= 1'b0;
						end
						// read bits follow the last location bit, msb first
						if (is_read && bit_r > `SEC_BITS_ADDR) begin
							rd_r <= {rd_r[6:0], di_s2_r};
						end
						// frame ends after its count of clocks
						if (bit_r == frame_bits) begin
							cs_r <= 1'b0;
							drv_r <= 1'b0;
							state_r <= ST_GAP;
						end
					end
				end

				ST_GAP: begin
					// select stays low for one half period before polling, and one clock longer between frames
					if (tick) begin
						if (ld_act_r) begin
							if (ld_idx_r == 3'h0 && rd_r != `SEC_SIGNATURE) begin
								// no signature: stop, address left as it was
								ld_act_r <= 1'b0;
								busy_r <= 1'b0;
								state_r <= ST_IDLE;
							end else begin
								// byte n of the load goes to address byte n-1
								if (ld_idx_r != 3'h0) begin
									sta_r[sta_base +: 8] <= rd_r;
								end
								if (ld_idx_r == `SEC_LAST_IDX) begin
									// loaded flag only after a full load
									loaded_r <= 1'b1;
									ld_act_r <= 1'b0;
									busy_r <= 1'b0;
									state_r <= ST_IDLE;
								end else begin
									ld_idx_r <= idx_inc;
									loc_r <= {4'h0, idx_inc};
									state_r <= ST_PREP;
								end
							end
						end else if (need_poll) begin
							// reassert select and watch data-out for ready
							cs_r <= 1'b1;
							saw_busy_r <= 1'b0;
							to_cnt_r <= {TO_W{1'b0}};
							state_r <= ST_POLL;
						end else begin
							// read data valid as busy drops
							if (is_read) begin
								data_r <= rd_r;
							end
							busy_r <= 1'b0;
							state_r <= ST_IDLE;
						end
					end
				end

				ST_POLL: begin
					// ready only counts after a busy low was seen, so a
					// floating line on an absent part cannot fake completion
					to_cnt_r <= to_cnt_r + {{(TO_W-1){1'b0}}, 1'b1};
					if (!di_s2_r) begin
						saw_busy_r <= 1'b1;
					end
					if (saw_busy_r && di_s2_r) begin
						cs_r <= 1'b0;
						busy_r <= 1'b0;
						state_r <= ST_IDLE;
					end else if (to_cnt_r == TO_LAST) begin
						to_r <= 1'b1;
						cs_r <= 1'b0;
						busy_r <= 1'b0;
						state_r <= ST_IDLE;
					end
				end

				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// pin stage: registered so the pins never glitch on the mux
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pin_cs_r <= 1'b0;
			pin_clk_r <= 1'b0;
			pin_do_r <= 1'b0;
			pin_oe_n_r <= 1'b1;
		end else if (if_disable) begin
			// pins reused as outputs or monitor taps
			pin_cs_r <= 1'b0;
			pin_clk_r <= mon_sel ? mon_clk : gpo_clk;
			pin_do_r <= mon_sel ? mon_data : gpo_data;
			pin_oe_n_r <= 1'b0;
		end else begin
			pin_cs_r <= cs_r;
			pin_clk_r <= sclk_r;
			pin_do_r <= sh_r[17];
			pin_oe_n_r <= ~drv_r;
		end
	end

endmodule // sec_ctrl

// *** src/sec_defines.vh ***
// constants of the serial eeprom controller: command codes, frame opcodes,
// timing figures and reset values; assumes a 10 MHz system clock.
`ifndef SEC_DEFINES_VH
`define SEC_DEFINES_VH

// host command codes
`define SEC_CMD_READ 3'h0
`define SEC_CMD_LOCK 3'h1
`define SEC_CMD_UNLOCK 3'h2
`define SEC_CMD_WRITE 3'h3
`define SEC_CMD_WRALL 3'h4
`define SEC_CMD_ERASE 3'h5
`define SEC_CMD_ERALL 3'h6
`define SEC_CMD_RELOAD 3'h7

// serial frame opcodes and the location bits of the extended group
`define SEC_OP_READ 2'h2
`define SEC_OP_WRITE 2'h1
`define SEC_OP_ERASE 2'h3
`define SEC_OP_EXT 2'h0
`define SEC_EXT_LOCK 2'h0
`define SEC_EXT_WRALL 2'h1
`define SEC_EXT_ERALL 2'h2
`define SEC_EXT_UNLOCK 2'h3

// frame lengths and the clock of the last location bit, in serial clocks
`define SEC_BITS_SHORT 5'h0A
`define SEC_BITS_LONG 5'h12
`define SEC_BITS_ADDR 5'h0A

// auto-load layout
`define SEC_SIGNATURE 8'hA5
`define SEC_SIG_LOC 7'h00
`define SEC_LAST_IDX 3'h6

// timing
`define SEC_CLK_HZ 10000000
`define SEC_TIMEOUT_MS 30
`define SEC_TIMEOUT_CYC (`SEC_CLK_HZ / 1000 * `SEC_TIMEOUT_MS)
`define SEC_TO_W 19
`define SEC_SCLK_HALF 5

// reset values
`define SEC_STA_RST 48'h000000000000
`define SEC_DATA_RST 8'h00

`endif

// *** verification/sec_ctrl_chk.sv ***
// checker of the controller ports: command handshake, frames, flags
// assumes one clock domain; bound to every sec_ctrl instance
`timescale 1ns/10ps
module sec_ctrl_chk #(
	parameter SCLK_HALF = 5,
	parameter TIMEOUT_CYC = 300000
) (
	// clock and reset
	input wire sys_clk,
	input wire nrst,
	// host side
	input wire busy_set,
	input wire timeout_clr,
	input wire data_wr,
	input wire sta_low_wr,
	input wire if_disable,
	input wire command_busy_flag,
	input wire response_timeout_flag,
	input wire address_loaded_flag,
	input wire [7:0] eeprom_data_reg,
	input wire [31:0] station_addr_low_reg,
	// eeprom pins
	input wire chip_select,
	input wire serial_clock_pin,
	input wire serial_data_pin_out,
	input wire serial_data_pin_oe_n
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);
	reg [4:0] nclk_r;
	reg sck_q_r;
	// rising serial clocks in one select window; a select gap clears it
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			nclk_r <= 5'h00;
			sck_q_r <= 1'b0;
		end else begin
			sck_q_r <= serial_clock_pin;
			if (!chip_select)
				nclk_r <= 5'h00;
			else if (serial_clock_pin && !sck_q_r)
				nclk_r <= nclk_r + 5'h01;
		end
	end
	sequence s_take;
		busy_set && !command_busy_flag && !if_disable;
	endsequence
	sequence s_end;
		$fell(chip_select) && !if_disable;
	endsequence
	property p_take;
		s_take |=> command_busy_flag;
	endproperty
	a_take: assert property (p_take) else $error("busy not raised");
	property p_len;
		s_end |-> nclk_r == 5'h0A || nclk_r == 5'h12 || nclk_r == 5'h00;
	endproperty
	a_len: assert property (p_len) else $error("bad clock count");
	property p_edge;
		chip_select && !serial_data_pin_oe_n && $changed(serial_data_pin_out) |-> !serial_clock_pin;
	endproperty
	a_edge: assert property (p_edge) else $error("data moved on high clock");
	property p_start;
		$rose(chip_select) && !serial_data_pin_oe_n |-> serial_data_pin_out;
	endproperty
	a_start: assert property (p_start) else $error("no start bit");
	property p_clr;
		timeout_clr && !command_busy_flag |=> !response_timeout_flag;
	endproperty
	a_clr: assert property (p_clr) else $error("timeout kept");
	property p_load;
		$rose(address_loaded_flag) |-> $past(command_busy_flag) ##[0:8] !command_busy_flag;
	endproperty
	a_load: assert property (p_load) else $error("loaded outside load");
	property p_data;
		$changed(eeprom_data_reg) |-> $past(command_busy_flag) || $past(data_wr);
	endproperty
	a_data: assert property (p_data) else $error("data moved alone");
	property p_addr;
		$changed(station_addr_low_reg) |-> $past(command_busy_flag) || $past(sta_low_wr);
	endproperty
	a_addr: assert property (p_addr) else $error("address moved alone");
endmodule // sec_ctrl_chk
bind sec_ctrl sec_ctrl_chk #(.SCLK_HALF(SCLK_HALF), .TIMEOUT_CYC(TIMEOUT_CYC)) chk_u (
	.sys_clk, .nrst, .busy_set, .timeout_clr, .data_wr, .sta_low_wr, .if_disable,
	.command_busy_flag, .response_timeout_flag, .address_loaded_flag, .eeprom_data_reg,
	.station_addr_low_reg, .chip_select, .serial_clock_pin, .serial_data_pin_out,
	.serial_data_pin_oe_n
);

// *** verification/sec_ctrl_tb.sv ***
// self-checking bench of the eeprom controller against a behavioural eeprom
// assumes the model and the checker with its bind are compiled first
`timescale 1ns/10ps
module sec_ctrl_tb;
	reg sys_clk = 1'b0, nrst = 1'b0, soft_rst = 1'b0, busy_set = 1'b0, timeout_clr = 1'b0;
	reg data_wr = 1'b0, sta_low_wr = 1'b0, sta_high_wr = 1'b0, if_disable = 1'b0;
	reg mon_sel = 1'b0, gpo_data = 1'b0, gpo_clk = 1'b0, mon_data = 1'b0, mon_clk = 1'b0;
	reg mute = 1'b0, slow = 1'b0;
	reg [2:0] command_code_field = 3'h0;
	reg [6:0] eeprom_location_field = 7'h00;
	reg [7:0] data_in = 8'h00;
	reg [31:0] sta_low_in = 32'h89ABCDEF;
	reg [15:0] sta_high_in = 16'h0123;
	wire command_busy_flag, response_timeout_flag, address_loaded_flag, chip_select;
	wire serial_clock_pin, serial_data_pin_out, serial_data_pin_oe_n, dq;
	wire [7:0] eeprom_data_reg;
	wire [31:0] station_addr_low_reg;
	wire [15:0] station_addr_high_reg;
	wire [47:0] sta = {station_addr_high_reg, station_addr_low_reg};
	// one wire level: whoever has the pin drives it
	wire serial_data_pin_in = serial_data_pin_oe_n ? dq : serial_data_pin_out;
	integer n_fail = 0, compares = 0, r, i;
	// unlock first; command, location, data written, data register afterwards
	reg [25:0] rows [0:12] = '{{3'h2, 7'h00, 8'h00, 8'h00}, {3'h3, 7'h05, 8'h3C, 8'h3C},
		{3'h0, 7'h05, 8'h00, 8'h3C}, {3'h5, 7'h05, 8'h00, 8'h00}, {3'h0, 7'h05, 8'h00, 8'hFF},
		{3'h1, 7'h00, 8'h00, 8'h00}, {3'h3, 7'h05, 8'h11, 8'h11}, {3'h0, 7'h05, 8'h00, 8'hFF},
		{3'h2, 7'h00, 8'h00, 8'h00}, {3'h4, 7'h00, 8'h5A, 8'h5A}, {3'h0, 7'h7F, 8'h00, 8'h5A},
		{3'h6, 7'h00, 8'h00, 8'h00}, {3'h0, 7'h00, 8'h00, 8'hFF}};
	sec_ctrl #(.SCLK_HALF(4), .TIMEOUT_CYC(200)) dut (.sys_clk, .nrst, .soft_rst,
		.command_code_field, .eeprom_location_field, .busy_set, .timeout_clr,
		.command_busy_flag, .response_timeout_flag, .address_loaded_flag, .data_wr, .data_in,
		.eeprom_data_reg, .sta_low_wr, .sta_low_in, .sta_high_wr, .sta_high_in,
		.station_addr_low_reg, .station_addr_high_reg, .if_disable, .mon_sel, .gpo_data,
		.gpo_clk, .mon_data, .mon_clk, .chip_select, .serial_clock_pin, .serial_data_pin_in,
		.serial_data_pin_out, .serial_data_pin_oe_n);
	sec_eeprom_model mem_u (.cs(chip_select), .sck(serial_clock_pin),
		.din(serial_data_pin_in), .dq(dq), .mute(mute), .slow(slow));
	initial forever #50 sys_clk = !sys_clk;
	task chk(input [47:0] exp, input [47:0] got, input [8*8:1] what);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				n_fail = n_fail + 1;
				$display("unexpected %0s: expected %h seen %h", what, exp, got);
			end
		end
	endtask
	task summarize;
		begin
			$display("compares %0d n_fail %0d", compares, n_fail);
			if (n_fail == 0 && compares > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	// signature, then six address bytes base+1 .. base+6
	task fill(input [7:0] b);
		begin
			mem_u.mem[0] = 8'hA5;
			for (i = 1; i < 7; i = i + 1)
				mem_u.mem[i] = b + i[7:0];
		end
	endtask
	// bounded wait for busy to rise, then to fall
	task wait_idle;
		begin
			i = 0;
			@(negedge sys_clk);
			while (command_busy_flag !== 1'b1 && i < 4) begin
				@(negedge sys_clk);
				i = i + 1;
			end
			while (command_busy_flag !== 1'b0 && i < 4000) begin
				@(negedge sys_clk);
				i = i + 1;
			end
			chk(0, command_busy_flag, "busy");
		end
	endtask
	// data first, then code and location with busy set
	task run(input [2:0] c, input [6:0] l, input [7:0] d);
		begin
			@(negedge sys_clk);
			data_in = d;
			data_wr = 1'b1;
			@(negedge sys_clk);
			data_wr = 1'b0;
			command_code_field = c;
			eeprom_location_field = l;
			busy_set = 1'b1;
			@(negedge sys_clk);
			busy_set = 1'b0;
			wait_idle;
		end
	endtask
	initial begin
		#3000000;
		n_fail = n_fail + 1;
		summarize;
	end
	initial begin
		#1;
		fill(8'h10);
		repeat (5) @(negedge sys_clk);
		nrst = 1'b1;
		wait_idle;
		chk(1, address_loaded_flag, "loaded");
		chk(48'h161514131211, sta, "station");
		for (r = 0; r < 13; r = r + 1) begin
			slow = r[0];
			run(rows[r][25:23], rows[r][22:16], rows[r][15:8]);
			chk(rows[r][7:0], eeprom_data_reg, "data");
		end
		$display("test rows done");
		@(negedge sys_clk);
		sta_low_wr = 1'b1;
		sta_high_wr = 1'b1;
		@(negedge sys_clk);
		sta_low_wr = 1'b0;
		sta_high_wr = 1'b0;
		run(3'h7, 7'h00, 8'h00);
		chk(0, address_loaded_flag, "loaded");
		chk(48'h012389ABCDEF, sta, "station");
		fill(8'h20);
		run(3'h7, 7'h00, 8'h00);
		chk(1, address_loaded_flag, "loaded");
		chk(48'h262524232221, sta, "station");
		mem_u.mem[1] = 8'h31;
		soft_rst = 1'b1;
		@(negedge sys_clk);
		soft_rst = 1'b0;
		wait_idle;
		chk(48'h262524232231, sta, "station");
		$display("test reload done");
		mute = 1'b1;
		run(3'h3, 7'h09, 8'h77);
		chk(1, response_timeout_flag, "timeout");
		timeout_clr = 1'b1;
		@(negedge sys_clk);
		timeout_clr = 1'b0;
		mute = 1'b0;
		@(negedge sys_clk);
		chk(0, response_timeout_flag, "timeout");
		$display("test timeout done");
		if_disable = 1'b1;
		gpo_data = 1'b1;
		gpo_clk = 1'b1;
		mon_data = 1'b1;
		busy_set = 1'b1;
		@(negedge sys_clk);
		busy_set = 1'b0;
		repeat (2) @(negedge sys_clk);
		chk(3, {serial_data_pin_out, serial_clock_pin}, "gpo");
		chk(0, command_busy_flag, "busy");
		mon_sel = 1'b1;
		gpo_data = 1'b0;
		repeat (2) @(negedge sys_clk);
		chk(2, {serial_data_pin_out, serial_clock_pin}, "monitor");
		if_disable = 1'b0;
		$display("test pins done");
		repeat (2) @(negedge sys_clk);
		nrst = 1'b0;
		@(negedge sys_clk);
		chk(1, {command_busy_flag, address_loaded_flag, chip_select, serial_data_pin_oe_n}, "reset");
		chk(0, sta, "station");
		nrst = 1'b1;
		wait_idle;
		chk(1, address_loaded_flag, "loaded");
		$display("test reset done");
		summarize;
	end
endmodule // sec_ctrl_tb

// *** verification/sec_eeprom_model.sv ***
// behavioural three-wire eeprom of 128 x 8 bits facing the controller pins
// assumes frames msb first under a high select, bits taken on rising clock
`timescale 1ns/10ps
module sec_eeprom_model (
	// pins
	input wire cs,
	input wire sck,
	input wire din,
	output wire dq,
	// bench controls: never ready while polling, long busy time
	input wire mute,
	input wire slow
);
	reg [7:0] mem [0:127];
	reg [4:0] n = 5'h00;
	reg [17:0] sh = 18'h00000;
	reg [1:0] op = 2'h0;
	reg [6:0] ad = 7'h00;
	reg en = 1'b0, mod = 1'b0, bsy = 1'b0, lst = 1'b0;
	integer k;
	wire rd = cs && op == 2'h2 && n > 5'h0A;
	wire poll = cs && n == 5'h00;
	// released line shows the inverse of the last level, never a stale copy
	assign dq = rd ? mem[ad][5'h12 - n] : poll ? !bsy && !mute : !lst;
	initial
		for (k = 0; k < 128; k = k + 1)
			mem[k] = 8'hFF;
	always @(posedge cs) begin
		n = 5'h00;
		op = 2'h0;
	end
	// shift in start, opcode, location; the command acts on its last
	// rising clock, as select may drop in the same step as the last falling one
	always @(posedge sck) begin
		if (rd || poll)
			lst = dq;
		if (cs) begin
			n = n + 5'h01;
			sh = {sh[16:0], din};
		end
		if (cs && n == 5'h0A) begin
			op = sh[8:7];
			ad = sh[6:0];
			if (op == 2'h0 && ad[6:5] == 2'h3)
				en = 1'b1;
			if (op == 2'h0 && ad[6:5] == 2'h0)
				en = 1'b0;
			if (en && op == 2'h3)
				mem[ad] = 8'hFF;
			if (en && op == 2'h0 && ad[6:5] == 2'h2)
				for (k = 0; k < 128; k = k + 1)
					mem[k] = 8'hFF;
			mod = en && (op == 2'h3 || (op == 2'h0 && ad[6:5] == 2'h2));
		end
		if (cs && n == 5'h12) begin
			if (en && op == 2'h1)
				mem[ad] = sh[7:0];
			if (en && op == 2'h0 && ad[6:5] == 2'h1)
				for (k = 0; k < 128; k = k + 1)
					mem[k] = sh[7:0];
			mod = en && (op == 2'h1 || (op == 2'h0 && ad[6:5] == 2'h1));
		end
	end
	// busy after a modifying frame, then ready
	always @(negedge cs)
		if (mod) begin
			mod = 1'b0;
			bsy = 1'b1;
			#(slow ? 4000 : 600);
			bsy = 1'b0;
		end
endmodule // sec_eeprom_model
